// file: psf_supervisor.v
// Power supply fault supervisor: sequencing, fault detection, LEDs.
//
// Notes on behaviour
// RULE1: On over-temperature drop power-good, then 2 ms later disable main and aux.
// RULE2: Ambient above 90 C and transformer above 120 C are separate faults.
// RULE3: Re-enable automatically when transformer is at most 110 C and ambient 80 C.
// RULE4: Main over-voltage latches; cleared by 5 s power loss or 25 ms request off.
// RULE5: Over-voltage trips at 120 percent of nominal, 116 to 124 tolerated.
// RULE6: Power-good falls when main stays below 90 percent for 4 ms.
// RULE7: Power-good returns after main stays above 93 percent for 4 ms.
// RULE8: Main below 80 percent over 30 ms: disable outputs, latch like over-voltage.
// RULE9: Main current above 120 percent over 10 ms shuts main and aux only.
// RULE10: Pulses shorter than 10 ms never trip the over-current detector.
// RULE11: After overload retry every 4 s for 5 minutes, then stay off.
// RULE12: Aux overload ignored; standby overload disables all until it clears.
// RULE13: Sustained power limit over 10 ms raises the under-voltage fault.
// RULE14: Outputs follow the active-low request; drives power-good and both LEDs.
// RULE15: Fault state persists through main and aux faults; standby powered.
// RULE16: While disabled by a fault, blinks darken power-good LED, light standby LED.
// RULE17: Long blink 1000 ms, short 300 ms, 100 ms between, 2000 ms repeat.
// RULE18: Codes: UV 5 short, OV 4, SC 3, OC 2, transformer L-S, ambient S-L.
// RULE19: Pattern repeats while faulted and stops once outputs are re-enabled.
`timescale 1ns/1ps
`include "psf_regs.vh"
module psf_supervisor #(
  parameter MS_CYCLES = `PSF_MS_CYC
) (
  input  wire clk,                     // 200 MHz clock.
  input  wire rstn,                    // Async reset, low.
  input  wire output_enable_request_n, // Host request, low.
  input  wire ac_present,              // Input power is on.
  input  wire main_below_90,           // Main below 90 pct.
  input  wire main_above_93,           // Main above 93 pct.
  input  wire main_below_80,           // Main below 80 pct.
  input  wire main_over_volt,          // Main above OV level.
  input  wire main_over_cur,           // Main current high.
  input  wire main_short,              // Main short circuit.
  input  wire power_limit,             // Power at limit.
  input  wire amb_hot,                 // Ambient above 90 C.
  input  wire amb_cool,                // Ambient 80 C or less.
  input  wire xfmr_hot,                // Transf. above 120 C.
  input  wire xfmr_cool,               // Transf. 110 C or less.
  input  wire aux_overload,            // Aux overload.
  input  wire standby_overload,        // Standby overload.
  output reg  main_output_en,          // Main output on.
  output reg  aux_output_en,           // Aux output on.
  output reg  output_ok_flag,          // Power-good.
  output reg  pg_led,                  // Power-good LED.
  output reg  standby_led,             // Standby LED.
  output reg  supply_off,              // Whole supply off.
  output reg  [2:0] fault_code         // Current fault.
);
  // ----------------------------------------------------------------
  // States and widths
  // ----------------------------------------------------------------
  localparam ST_OFF   = 2'h0;
  localparam ST_ON    = 2'h1;
  localparam ST_OTW   = 2'h2;
  localparam ST_FAULT = 2'h3;
  localparam NIN      = 15;
  localparam [NIN-1:0] PIN_IDLE = 15'h0003;
  localparam TW       = 19;
  localparam PW       = 18;
  // The first tick may come at once, so one more keeps the delay at 2 ms or more.
  localparam [TW-1:0] OT_OFF   = `PSF_OT_OFF_MS + 1;
  localparam [TW-1:0] RETRY    = `PSF_RETRY_MS;
  localparam [TW-1:0] SPAN     = `PSF_SPAN_MS;
  localparam [PW-1:0] PRE_LAST = MS_CYCLES - 1;

  // ----------------------------------------------------------------
  // Pin synchronisers
  // ----------------------------------------------------------------
  // Every pin passes three flops; a change counts once the last two
  // agree, which also rejects a one-cycle glitch; reset loads idle levels, not a request.
  wire [NIN-1:0] pin_raw = {aux_overload, standby_overload,
                            xfmr_cool, xfmr_hot, amb_cool,
                            amb_hot, power_limit, main_short,
                            main_over_cur, main_over_volt,
                            main_below_80, main_above_93,
                            main_below_90, ac_present,
                            output_enable_request_n};
  reg  [NIN-1:0] s1_q;
  reg  [NIN-1:0] s2_q;
  reg  [NIN-1:0] s3_q;
  reg  [NIN-1:0] pin_q;

  always @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      s1_q  <= PIN_IDLE;
      s2_q  <= PIN_IDLE;
      s3_q  <= PIN_IDLE;
      pin_q <= PIN_IDLE;
    end else begin
      s1_q  <= pin_raw;
      s2_q  <= s1_q;
      s3_q  <= s2_q;
      pin_q <= (s2_q & s3_q) | (pin_q & (s2_q ^ s3_q));
    end
  end

  wire req       = ~pin_q[0];  // RULE14
  wire ac_ok     = pin_q[1];
  wire lo90      = pin_q[2];
  wire hi93      = pin_q[3];
  wire lo80      = pin_q[4];
  wire ov        = pin_q[5];  // RULE5
  wire oc        = pin_q[6];
  wire sc        = pin_q[7];
  wire plim      = pin_q[8];
  wire a_hot     = pin_q[9];
  wire a_cool    = pin_q[10];
  wire x_hot     = pin_q[11];
  wire x_cool    = pin_q[12];
  wire sb_ovl    = pin_q[13];
  // Aux overload is sensed but deliberately has no effect.
  wire aux_ovl   = pin_q[14];

  // ----------------------------------------------------------------
  // Millisecond timebase
  // ----------------------------------------------------------------
  reg [PW-1:0] pre_q;
  reg          tick_q;

  always @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      pre_q  <= {PW{1'b0}};
      tick_q <= 1'b0;
    end else if (pre_q >= PRE_LAST) begin
      pre_q  <= {PW{1'b0}};
      tick_q <= 1'b1;
    end else begin
      pre_q  <= pre_q + {{(PW-1){1'b0}}, 1'b1};
      tick_q <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // Dwell filters
  // ----------------------------------------------------------------
  reg  [1:0] st_q;
  wire       live = (st_q == ST_ON);
  wire       pg_fall;
  wire       pg_rise;
  wire       uv_trip;
  wire       oc_trip;
  wire       sc_trip;
  wire       pw_trip;
  wire       req_off_long;
  wire       ac_off_long;

  psf_dwell #(.W(4), .MS(`PSF_PG_DWELL_MS)) u_pg_fall (
    .clk  (clk),
    .rstn (rstn),
    .tick (tick_q),
    .cond (live & lo90),
    .done (pg_fall)
  );

  psf_dwell #(.W(4), .MS(`PSF_PG_DWELL_MS)) u_pg_rise (
    .clk  (clk),
    .rstn (rstn),
    .tick (tick_q),
    .cond (live & hi93 & ~lo90),
    .done (pg_rise)
  );

  // Strictly more than the limit, hence one extra millisecond.
  psf_dwell #(.W(6), .MS(`PSF_UV_MS + 1)) u_uv (
    .clk  (clk),
    .rstn (rstn),
    .tick (tick_q),
    .cond (live & lo80),
    .done (uv_trip)
  );

  psf_dwell #(.W(5), .MS(`PSF_OC_MS + 1)) u_oc (
    .clk  (clk),
    .rstn (rstn),
    .tick (tick_q),
    .cond (live & oc),
    .done (oc_trip)
  );

  psf_dwell #(.W(5), .MS(`PSF_OC_MS + 1)) u_sc (
    .clk  (clk),
    .rstn (rstn),
    .tick (tick_q),
    .cond (live & sc),
    .done (sc_trip)
  );

  psf_dwell #(.W(5), .MS(`PSF_PWR_MS + 1)) u_pw (
    .clk  (clk),
    .rstn (rstn),
    .tick (tick_q),
    .cond (live & plim),
    .done (pw_trip)
  );

  psf_dwell #(.W(5), .MS(`PSF_REQ_OFF_MS)) u_req (
    .clk  (clk),
    .rstn (rstn),
    .tick (tick_q),
    .cond (~req),
    .done (req_off_long)
  );

  psf_dwell #(.W(13), .MS(`PSF_AC_OFF_MS)) u_ac (
    .clk  (clk),
    .rstn (rstn),
    .tick (tick_q),
    .cond (~ac_ok),
    .done (ac_off_long)
  );

  // ----------------------------------------------------------------
  // Sequencer
  // ----------------------------------------------------------------
  reg  [1:0]    st_d;
  reg  [2:0]    flt_q;
  reg  [2:0]    flt_d;
  reg  [TW-1:0] tmr_q;
  reg  [TW-1:0] tmr_d;
  reg  [TW-1:0] span_q;
  reg  [TW-1:0] span_d;
  reg           retry_q;
  reg           retry_d;
  reg           quit_q;
  reg           quit_d;
  reg           rearm_q;
  reg           rearm_d;
  reg           aclong_q;
  reg           aclong_d;
  reg           pg_q;
  reg           pg_d;
  wire          ot_any = a_hot | x_hot;  // RULE2

  always @* begin
    st_d     = st_q;
    flt_d    = flt_q;
    tmr_d    = tmr_q;
    span_d   = span_q;
    retry_d  = retry_q;
    quit_d   = quit_q;
    rearm_d  = rearm_q;
    aclong_d = aclong_q | ac_off_long;
    if (tick_q && tmr_q != {TW{1'b1}}) begin
      tmr_d = tmr_q + {{(TW-1){1'b0}}, 1'b1};
    end
    if (tick_q && retry_q && span_q != {TW{1'b1}}) begin
      span_d = span_q + {{(TW-1){1'b0}}, 1'b1};
    end
    case (st_q)
      ST_OFF: begin
        if (req) begin
          st_d  = ST_ON;
          tmr_d = {TW{1'b0}};
        end
      end
      ST_ON: begin
        if (retry_q && tmr_q >= RETRY) begin
          retry_d = 1'b0;  // RULE11
        end
        if (ot_any) begin
          st_d  = ST_OTW;  // RULE1
          flt_d = x_hot ? `PSF_F_OTX : `PSF_F_OTA;
          tmr_d = {TW{1'b0}};
        end else if (ov) begin
          st_d  = ST_FAULT;  // RULE4
          flt_d = `PSF_F_OV;
        end else if (uv_trip || pw_trip) begin
          st_d  = ST_FAULT;  // RULE8 RULE13
          flt_d = `PSF_F_UV;
        end else if (sc_trip || oc_trip) begin
          st_d  = ST_FAULT;  // RULE9 RULE10
          flt_d = sc_trip ? `PSF_F_SC : `PSF_F_OC;
          if (!retry_q) begin
            retry_d = 1'b1;
            span_d  = {TW{1'b0}};
          end
        end else if (!req) begin
          st_d = ST_OFF;
        end
        if (st_d == ST_FAULT) begin
          tmr_d   = {TW{1'b0}};
          rearm_d = 1'b0;
        end
      end
      ST_OTW: begin
        if (tmr_q >= OT_OFF) begin
          st_d  = ST_FAULT;  // RULE1
          tmr_d = {TW{1'b0}};
        end
      end
      ST_FAULT: begin
        case (flt_q)
          `PSF_F_OTX, `PSF_F_OTA: begin
            if (x_cool && a_cool && !ot_any) begin
              st_d  = req ? ST_ON : ST_OFF;  // RULE3
              flt_d = `PSF_F_NONE;
              tmr_d = {TW{1'b0}};
            end
          end
          `PSF_F_SC, `PSF_F_OC: begin
            if (quit_q || span_q >= SPAN) begin
              quit_d = 1'b1;  // RULE11
            end else if (tmr_q >= RETRY) begin
              st_d  = ST_ON;  // RULE11
              flt_d = `PSF_F_NONE;
              tmr_d = {TW{1'b0}};
            end
          end
          default: begin
            if (rearm_q && req) begin
              st_d  = ST_ON;  // RULE4 RULE8
              flt_d = `PSF_F_NONE;
              tmr_d = {TW{1'b0}};
            end
          end
        endcase
        if (req_off_long) begin
          rearm_d = 1'b1;  // RULE4
        end
      end
      default: begin
        st_d = ST_OFF;
      end
    endcase
    // Input power back after a long absence wipes every latched fault.
    if (aclong_q && ac_ok) begin
      st_d     = ST_OFF;  // RULE4 RULE11
      flt_d    = `PSF_F_NONE;
      retry_d  = 1'b0;
      quit_d   = 1'b0;
      rearm_d  = 1'b0;
      aclong_d = 1'b0;
    end
  end

  // Power-good is held low except while running; OT forces it low first.
  always @* begin
    pg_d = pg_q;
    if (!live || ot_any || sb_ovl) begin
      pg_d = 1'b0;  // RULE1 RULE8
    end else if (pg_fall) begin
      pg_d = 1'b0;  // RULE6
    end else if (pg_rise) begin
      pg_d = 1'b1;  // RULE7
    end
  end

  always @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      st_q     <= ST_OFF;
      flt_q    <= `PSF_F_NONE;
      tmr_q    <= {TW{1'b0}};
      span_q   <= {TW{1'b0}};
      retry_q  <= 1'b0;
      quit_q   <= 1'b0;
      rearm_q  <= 1'b0;
      aclong_q <= 1'b0;
      pg_q     <= 1'b0;
    end else begin
      st_q     <= st_d;  // RULE15
      flt_q    <= flt_d;
      tmr_q    <= tmr_d;
      span_q   <= span_d;
      retry_q  <= retry_d;
      quit_q   <= quit_d;
      rearm_q  <= rearm_d;
      aclong_q <= aclong_d;
      pg_q     <= pg_d;
    end
  end

  // ----------------------------------------------------------------
  // Outputs and indicators
  // ----------------------------------------------------------------
  wire blink;
  wire faulted = (st_q == ST_FAULT);
  wire run_en  = (st_d == ST_ON || st_d == ST_OTW) && !sb_ovl;

  psf_blink u_blink (
    .clk   (clk),
    .rstn  (rstn),
    .tick  (tick_q),
    .run   (faulted),
    .code  (flt_q),
    .blink (blink)
  );

  always @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      main_output_en <= 1'b0;
      aux_output_en  <= 1'b0;
      output_ok_flag <= 1'b0;
      pg_led         <= 1'b0;
      standby_led    <= 1'b0;
      supply_off     <= 1'b0;
      fault_code     <= `PSF_F_NONE;
    end else begin
      main_output_en <= run_en;  // RULE14 RULE9
      aux_output_en  <= run_en;  // RULE12
      output_ok_flag <= pg_d;
      pg_led         <= faulted ? ~blink : pg_d;  // RULE16
      standby_led    <= faulted & blink;  // RULE16 RULE19
      supply_off     <= sb_ovl;  // RULE12
      fault_code     <= flt_d;
    end
  end
endmodule // psf_supervisor

// file: psf_regs.vh
// Constants of the power supply fault supervisor.
`ifndef PSF_REGS_VH
`define PSF_REGS_VH
// ----------------------------------------------------------------
// Clock and timebase
// ----------------------------------------------------------------
`define PSF_CLK_MHZ      200
`define PSF_MS_CYC       (`PSF_CLK_MHZ * 1000)
// ----------------------------------------------------------------
// Analog thresholds, applied by the comparators outside, in percent, C and W
// ----------------------------------------------------------------
`define PSF_OV_MIN_PCT   116
`define PSF_OV_NOM_PCT   120
`define PSF_OV_MAX_PCT   124
`define PSF_PG_FALL_PCT  90
`define PSF_PG_RISE_PCT  93
`define PSF_UV_PCT       80
`define PSF_OC_PCT       120
`define PSF_PULSE_PCT    150
`define PSF_STEADY_PCT   93
`define PSF_DUTY_PCT     10
`define PSF_OT_AMB_C     90
`define PSF_OT_XFMR_C    120
`define PSF_COOL_AMB_C   80
`define PSF_COOL_XFMR_C  110
`define PSF_PWR_LIM_W    520
// ----------------------------------------------------------------
// Times in milliseconds
// ----------------------------------------------------------------
`define PSF_OT_OFF_MS    2
`define PSF_PG_DWELL_MS  4
`define PSF_UV_MS        30
`define PSF_OC_MS        10
`define PSF_PWR_MS       10
`define PSF_REQ_OFF_MS   25
`define PSF_AC_OFF_MS    5000
`define PSF_RETRY_MS     4000
`define PSF_SPAN_MS      300000
`define PSF_LONG_MS      1000
`define PSF_SHORT_MS     300
`define PSF_GAP_MS       100
`define PSF_REPEAT_MS    2000
// ----------------------------------------------------------------
// Fault codes
// ----------------------------------------------------------------
`define PSF_F_NONE       3'h0
`define PSF_F_UV         3'h1
`define PSF_F_OV         3'h2
`define PSF_F_SC         3'h3
`define PSF_F_OC         3'h4
`define PSF_F_OTX        3'h5
`define PSF_F_OTA        3'h6
`endif

// file: psf_dwell.v
// Dwell timer: flags a condition that has held for a number of ms.
`timescale 1ns/1ps
module psf_dwell #(
  parameter W  = 13,
  parameter MS = 4
) (
  input  wire clk,   // System clock.
  input  wire rstn,  // Asynchronous reset, active low.
  input  wire tick,  // One-cycle pulse each millisecond.
  input  wire cond,  // Condition being timed.
  output wire done   // Condition has held MS ticks.
);
  reg [W-1:0] cnt_q;
  assign done = cond && (cnt_q >= MS[W-1:0]);
  // A drop of the condition restarts the count, so short pulses never mature.
  always @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      cnt_q <= {W{1'b0}};
    end else if (!cond) begin
      cnt_q <= {W{1'b0}};
    end else if (tick && !done) begin
      cnt_q <= cnt_q + {{(W-1){1'b0}}, 1'b1};
    end
  end
endmodule // psf_dwell

// file: psf_blink.v
// Fault code blinker: long and short blinks with pauses, repeated.
`timescale 1ns/1ps
`include "psf_regs.vh"
module psf_blink (
  input  wire       clk,    // System clock.
  input  wire       rstn,   // Asynchronous reset, active low.
  input  wire       tick,   // One-cycle pulse each millisecond.
  input  wire       run,    // Outputs are disabled by a fault.
  input  wire [2:0] code,   // Fault code to show.
  output reg        blink   // High during each blink.
);
  localparam S_IDLE = 2'h0;
  localparam S_ON   = 2'h1;
  localparam S_GAP  = 2'h2;
  localparam [11:0] LONG_MS   = `PSF_LONG_MS;
  localparam [11:0] SHORT_MS  = `PSF_SHORT_MS;
  localparam [11:0] GAP_MS    = `PSF_GAP_MS;
  localparam [11:0] REPEAT_MS = `PSF_REPEAT_MS;

  function [2:0] n_elem;
    input [2:0] c;
    begin
      case (c)
        `PSF_F_UV:  n_elem = 3'h5;
        `PSF_F_OV:  n_elem = 3'h4;
        `PSF_F_SC:  n_elem = 3'h3;
        `PSF_F_OC, `PSF_F_OTX, `PSF_F_OTA: n_elem = 3'h2;
        default:    n_elem = 3'h0;
      endcase
    end
  endfunction

  function [11:0] on_len;
    input [2:0] c;
    input [2:0] i;
    begin
      if ((c == `PSF_F_OTX && i == 3'h0) || (c == `PSF_F_OTA && i == 3'h1)) begin
        on_len = LONG_MS;
      end else begin
        on_len = SHORT_MS;
      end
    end
  endfunction

  reg [1:0]  st_q;
  reg [2:0]  idx_q;
  reg [11:0] cnt_q;
  wire       last = (idx_q + 3'h1) >= n_elem(code);

  always @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      st_q  <= S_IDLE;
      idx_q <= 3'h0;
      cnt_q <= 12'h000;
      blink <= 1'b0;
    end else if (!run || n_elem(code) == 3'h0) begin
      st_q  <= S_IDLE;  // RULE19
      idx_q <= 3'h0;
      cnt_q <= 12'h000;
      blink <= 1'b0;
    end else begin
      case (st_q)
        S_IDLE: begin
          if (tick) begin
            st_q  <= S_ON;
            blink <= 1'b1;  // RULE16
          end
        end
        S_ON: begin
          if (cnt_q >= on_len(code, idx_q)) begin
            st_q  <= S_GAP;  // RULE17
            cnt_q <= 12'h000;
            blink <= 1'b0;
          end else if (tick) begin
            cnt_q <= cnt_q + 12'h001;
          end
        end
        S_GAP: begin
          if (cnt_q >= (last ? REPEAT_MS : GAP_MS)) begin
            st_q  <= S_ON;  // RULE17
            cnt_q <= 12'h000;
            idx_q <= last ? 3'h0 : idx_q + 3'h1;  // RULE18
            blink <= 1'b1;
          end else if (tick) begin
            cnt_q <= cnt_q + 12'h001;
          end
        end
        default: begin
          st_q  <= S_IDLE;
          blink <= 1'b0;
        end
      endcase
    end
  end
endmodule // psf_blink

// file: psf_supervisor_chk.sv
// Assertion checker for the power supply fault supervisor.
`timescale 1ns/1ps
module psf_supervisor_chk #(
  parameter MS_CYCLES = 200000
) (
  input wire       clk,                     // Clock.
  input wire       rstn,                    // Reset, low.
  input wire       output_enable_request_n, // Request, low.
  input wire       main_below_80,           // Below 80 pct.
  input wire       main_over_volt,          // Over-voltage.
  input wire       main_over_cur,           // Over-current.
  input wire       main_output_en,          // Main on.
  input wire       aux_output_en,           // Aux on.
  input wire       output_ok_flag,          // Power-good.
  input wire       pg_led,                  // PG LED.
  input wire       standby_led,             // Standby LED.
  input wire       supply_off,              // Supply off.
  input wire [2:0] fault_code               // Fault.
);
  localparam int SHORT = 300 * MS_CYCLES;
  localparam int LONG  = 1000 * MS_CYCLES;
  // ----------------------------------------------------------------
  // Run lengths in cycles, so ms figures compare exactly.
  // ----------------------------------------------------------------
  reg [31:0] pg_lo_q, hi_q, b80_q, oc_q;
  always @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      pg_lo_q <= 32'h0;
      hi_q    <= 32'h0;
      b80_q   <= 32'h0;
      oc_q    <= 32'h0;
    end else begin
      pg_lo_q <= output_ok_flag ? 32'h0 : pg_lo_q + 32'h1;
      hi_q    <= standby_led ? hi_q + 32'h1 : 32'h0;
      b80_q   <= main_below_80 ? b80_q + 32'h1 : 32'h0;
      oc_q    <= main_over_cur ? oc_q + 32'h1 : 32'h0;
    end
  end
  default clocking @(posedge clk); endclocking
  default disable iff (!rstn);
  sequence s_ov; main_over_volt [*8]; endsequence
  sequence s_end; $fell(standby_led) ##1 (fault_code != 3'h0 && !main_output_en); endsequence
  property p_pair; aux_output_en == main_output_en; endproperty
  a_pair: assert property (p_pair) else $error("enables differ");
  property p_ov; s_ov |-> ##[0:4] !main_output_en; endproperty
  a_ov: assert property (p_ov) else $error("no ov shutdown");
  property p_latch; fault_code == 3'h2 |-> !main_output_en; endproperty
  a_latch: assert property (p_latch) else $error("ov not latched");
  property p_pg; output_ok_flag |-> main_output_en || $past(main_output_en); endproperty
  a_pg: assert property (p_pg) else $error("pg while off");
  property p_ot;
    $fell(main_output_en) && fault_code >= 3'h5
      |-> pg_lo_q + 2 >= 2 * MS_CYCLES && pg_lo_q <= 3 * MS_CYCLES + 4;
  endproperty
  a_ot: assert property (p_ot) else $error("ot delay wrong");
  property p_len;
    s_end |-> ($past(hi_q) + 2 >= SHORT && $past(hi_q) <= SHORT + 2)
      || (fault_code >= 3'h5 && $past(hi_q) + 2 >= LONG && $past(hi_q) <= LONG + 2);
  endproperty
  a_len: assert property (p_len) else $error("blink length wrong");
  property p_leds; (!main_output_en && fault_code != 3'h0 && !supply_off) [*3]
    |-> pg_led != standby_led; endproperty
  a_leds: assert property (p_leds) else $error("fault leds wrong");
  property p_norm; main_output_en [*3]
    |-> !standby_led && (pg_led == output_ok_flag || pg_led == $past(output_ok_flag));
  endproperty
  a_norm: assert property (p_norm) else $error("leds not normal");
  property p_req; output_enable_request_n [*8] |=> !main_output_en; endproperty
  a_req: assert property (p_req) else $error("request off ignored");
  property p_uv; fault_code == 3'h1 && $changed(fault_code) |-> b80_q >= 30*MS_CYCLES; endproperty
  a_uv: assert property (p_uv) else $error("uv too early");
  property p_oc; fault_code == 3'h4 && $changed(fault_code) |-> oc_q >= 10*MS_CYCLES; endproperty
  a_oc: assert property (p_oc) else $error("oc too early");
  property p_sb; supply_off [*2] |-> !main_output_en; endproperty
  a_sb: assert property (p_sb) else $error("standby overload");
endmodule // psf_supervisor_chk
bind psf_supervisor psf_supervisor_chk #(.MS_CYCLES(MS_CYCLES)) u_chk (
  .clk(clk), .rstn(rstn), .output_enable_request_n(output_enable_request_n),
  .main_below_80(main_below_80), .main_over_volt(main_over_volt),
  .main_over_cur(main_over_cur), .main_output_en(main_output_en),
  .aux_output_en(aux_output_en), .output_ok_flag(output_ok_flag), .pg_led(pg_led),
  .standby_led(standby_led), .supply_off(supply_off), .fault_code(fault_code));

// file: psf_host.sv
// Host side model: drives the enable request and counts fault blinks.
`timescale 1ns/1ps
module psf_host #(
  parameter HOLD = 125
) (
  input  wire       clk,                     // Clock.
  input  wire       want,                    // Outputs wanted.
  input  wire       clr,                     // Clear count.
  input  wire       standby_led,             // Standby LED.
  output reg        output_enable_request_n = 1'b1, // Request, low.
  output reg  [7:0] blinks = 8'h0                   // Blinks seen.
);
  reg [31:0] off_q = 32'hFFFF;
  reg        led_q = 1'b0;
  // A shorter drop would not rearm a latched fault, so it is stretched.
  always @(posedge clk) begin
    off_q <= output_enable_request_n ? off_q + 32'h1 : 32'h0;
    if (!want)
      output_enable_request_n <= 1'b1;
    else if (off_q >= HOLD)
      output_enable_request_n <= 1'b0;
    led_q  <= standby_led;
    blinks <= clr ? 8'h0 : blinks + {7'h0, standby_led & ~led_q};
  end
endmodule // psf_host

// file: psu_fault_supervisor_bench.sv
// Self-checking bench for the power supply fault supervisor.
`timescale 1ns/1ps
`define CK(n, e, a) begin #1; checks++; if ((a) !== (e)) begin err_total++; \
  $display("BAD %s expected %0h seen %0h", n, e, a); end end
module psu_fault_supervisor_bench;
  localparam MS = 5;
  integer    err_total = 0;
  integer    checks    = 0;
  reg        clk = 1'b0, rstn = 1'b0, want = 1'b0, clr = 1'b0;
  reg        b90 = 1'b0, a93 = 1'b1, b80 = 1'b0, ov = 1'b0, oc = 1'b0, ac = 1'b1;
  reg        ahot = 1'b0, acool = 1'b1, xhot = 1'b0, xcool = 1'b1, aol = 1'b0, sol = 1'b0;
  wire       req_n, en_m, en_a, pg, pg_led, sb_led, soff;
  wire [2:0] code;
  wire [7:0] blinks;
  always #2.5 clk = ~clk;
  psf_host #(.HOLD(25 * MS)) u_host (.clk(clk), .want(want), .clr(clr),
    .standby_led(sb_led), .output_enable_request_n(req_n), .blinks(blinks));
  psf_supervisor #(.MS_CYCLES(MS)) dut (.clk(clk), .rstn(rstn),
    .output_enable_request_n(req_n), .ac_present(ac), .main_below_90(b90),
    .main_above_93(a93), .main_below_80(b80), .main_over_volt(ov), .main_over_cur(oc),
    .main_short(1'b0), .power_limit(1'b0), .amb_hot(ahot), .amb_cool(acool),
    .xfmr_hot(xhot), .xfmr_cool(xcool), .aux_overload(aol), .standby_overload(sol),
    .main_output_en(en_m), .aux_output_en(en_a), .output_ok_flag(pg), .pg_led(pg_led),
    .standby_led(sb_led), .supply_off(soff), .fault_code(code));
  // ----------------------------------------------------------------
  // Shared steps
  // ----------------------------------------------------------------
  task wait_ms(input integer n);
    repeat (n * MS) @(posedge clk);
  endtask
  task arm;
    clr <= 1'b1;
    @(posedge clk);
    clr <= 1'b0;
  endtask
  task recycle;
    wait_ms(1);
    want <= 1'b0;
    wait_ms(30);
    want <= 1'b1;
    wait_ms(2);
  endtask
  task final_report;
    if (err_total == 0 && checks > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task t_start;
    `CK("en", 1'b0, en_m)
    wait_ms(1);
    want <= 1'b1;
    aol  <= 1'b1;
    wait_ms(2);
    `CK("en", 1'b1, en_m)
    `CK("pg", 1'b0, pg)
    wait_ms(5);
    `CK("pg", 1'b1, pg)
    `CK("aux", 1'b1, en_a)
  endtask
  task t_pg;
    wait_ms(1);
    b90 <= 1'b1;
    a93 <= 1'b0;
    wait_ms(2);
    `CK("pg", 1'b1, pg)
    wait_ms(4);
    b90 <= 1'b0;
    a93 <= 1'b1;
    `CK("pg", 1'b0, pg)
    wait_ms(2);
    `CK("pg", 1'b0, pg)
    wait_ms(4);
    `CK("pg", 1'b1, pg)
  endtask
  task t_ov;
    wait_ms(1);
    arm;
    ov <= 1'b1;
    wait_ms(2);
    ov <= 1'b0;
    `CK("en", 1'b0, en_m)
    `CK("code", 3'h2, code)
    wait_ms(2100);
    `CK("blinks", 8'h4, blinks)
    `CK("en", 1'b0, en_m)
    recycle;
    `CK("en", 1'b1, en_m)
    `CK("sb", 1'b0, sb_led)
  endtask
  task t_uv;
    wait_ms(6);
    arm;
    b80 <= 1'b1;
    wait_ms(25);
    `CK("en", 1'b1, en_m)
    wait_ms(10);
    b80 <= 1'b0;
    `CK("en", 1'b0, en_m)
    `CK("pg", 1'b0, pg)
    `CK("code", 3'h1, code)
    wait_ms(2060);
    `CK("blinks", 8'h5, blinks)
    ac <= 1'b0;
    wait_ms(5002);
    ac <= 1'b1;
    wait_ms(2);
    `CK("en", 1'b1, en_m)
  endtask
  task t_oc;
    integer i;
    wait_ms(6);
    arm;
    oc <= 1'b1;
    wait_ms(5);
    oc <= 1'b0;
    `CK("en", 1'b1, en_m)
    wait_ms(45);
    oc <= 1'b1;
    wait_ms(15);
    oc <= 1'b0;
    `CK("en", 1'b0, en_m)
    `CK("off", 1'b0, soff)
    `CK("code", 3'h4, code)
    wait_ms(2090);
    `CK("blinks", 8'h2, blinks)
    i = 0;
    while (en_m !== 1'b1 && i < 2500 * MS) begin
      @(posedge clk);
      i++;
    end
    `CK("en", 1'b1, en_m)
  endtask
  task t_ot;
    wait_ms(6);
    arm;
    ahot  <= 1'b1;
    acool <= 1'b0;
    wait_ms(1);
    `CK("pg", 1'b0, pg)
    `CK("en", 1'b1, en_m)
    `CK("code", 3'h6, code)
    wait_ms(4);
    `CK("en", 1'b0, en_m)
    wait_ms(2096);
    ahot <= 1'b0;
    `CK("blinks", 8'h2, blinks)
    wait_ms(10);
    acool <= 1'b1;
    `CK("en", 1'b0, en_m)
    wait_ms(6);
    xhot  <= 1'b1;
    xcool <= 1'b0;
    `CK("en", 1'b1, en_m)
    wait_ms(5);
    xhot  <= 1'b0;
    xcool <= 1'b1;
    `CK("code", 3'h5, code)
    `CK("en", 1'b0, en_m)
    wait_ms(2);
    `CK("en", 1'b1, en_m)
  endtask
  task t_sb;
    wait_ms(6);
    sol <= 1'b1;
    wait_ms(1);
    sol <= 1'b0;
    `CK("off", 1'b1, soff)
    `CK("en", 1'b0, en_m)
    wait_ms(2);
    `CK("en", 1'b1, en_m)
  endtask
  initial begin
    repeat (2) @(posedge clk);
    rstn <= 1'b1;
    t_start;
    t_pg;
    t_ov;
    t_uv;
    t_oc;
    t_ot;
    t_sb;
    final_report;
  end
  initial begin
    repeat (90000) @(posedge clk);
    err_total++;
    final_report;
  end
endmodule // psu_fault_supervisor_bench
